// File: pcpl_pkg.sv
// constants and types shared by the control-pin logic
package pcpl_pkg;

  // ************************************************************
  // clock and time base
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_TIME_NS    = 1000000;
  localparam int unsigned MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOT_TIME_NS  = 10000;
  localparam int unsigned SLOT_CYCLES   = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned DISCH_TIME_NS = 30000;
  localparam int unsigned DISCH_CYCLES  = DISCH_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TEST_TIME_NS  = 100000;
  localparam int unsigned TEST_CYCLES_DEF = TEST_TIME_NS / CLK_PERIOD_NS;

  // ************************************************************
  // debounce and hold times in milliseconds
  // ************************************************************
  localparam logic [9:0]  DBNC_32_MS   = 10'd32;
  localparam logic [9:0]  DBNC_125_MS  = 10'd125;
  localparam logic [9:0]  DBNC_750_MS  = 10'd750;
  localparam logic [14:0] HOLD1_MS     = 15'd1000;
  localparam logic [14:0] HOLD2_MS     = 15'd2000;
  localparam logic [14:0] HOLD3_MS     = 15'd3000;
  localparam logic [14:0] HOLD4_MS     = 15'd4000;
  localparam logic [14:0] HOLD8_MS     = 15'd8000;
  localparam logic [14:0] LONG_2S_MS   = 15'd2000;
  localparam logic [14:0] LONG_4S_MS   = 15'd4000;
  localparam logic [14:0] LONG_8S_MS   = 15'd8000;
  localparam logic [14:0] LONG_16S_MS  = 15'd16000;
  localparam logic [14:0] HOLD_MAX_MS  = 15'h7fff;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LATCH  = 8'h01;
  localparam logic [7:0] ADDR_MASK   = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;

  // control register fields
  localparam int unsigned CTRL_RST_EN  = 0;
  localparam int unsigned CTRL_DLY_LO  = 1;
  localparam int unsigned CTRL_DBNC_LO = 3;
  localparam int unsigned CTRL_SB_INV  = 5;
  localparam int unsigned CTRL_TEST    = 6;

  // latch and mask bit positions
  localparam int unsigned INT_PRESS   = 0;
  localparam int unsigned INT_RELEASE = 1;
  localparam int unsigned INT_HOLD1   = 2;
  localparam int unsigned INT_HOLD2   = 3;
  localparam int unsigned INT_HOLD3   = 4;
  localparam int unsigned INT_HOLD4   = 5;
  localparam int unsigned INT_HOLD8   = 6;
  localparam int unsigned INT_W       = 7;

  // status register fields
  localparam int unsigned STAT_LEVEL   = 0;
  localparam int unsigned STAT_STANDBY = 1;
  localparam int unsigned STAT_MODE    = 2;
  localparam int unsigned STAT_ON      = 3;
  localparam int unsigned STAT_HRST    = 4;

  // reset values
  localparam logic [6:0] MASK_RST    = 7'h00;
  localparam logic       SB_INV_RST  = 1'b0;
  localparam logic       RST_EN_RST  = 1'b0;

  // ************************************************************
  // system power states
  // ************************************************************
  typedef enum logic [4:0] {
    PCPL_OFF   = 5'b00001,
    PCPL_PWRUP = 5'b00010,
    PCPL_ON    = 5'b00100,
    PCPL_PWRDN = 5'b01000,
    PCPL_DISCH = 5'b10000
  } pcpl_state_t;

endpackage

// File: pcpl_top.sv
// control-pin logic: power button, standby input, host reset and interrupt pins
`timescale 1ns/1ns
`default_nettype none

module pcpl_top #(
  parameter int unsigned MS_CYCLES   = pcpl_pkg::MS_CYCLES_DEF,
  parameter int unsigned TEST_CYCLES = pcpl_pkg::TEST_CYCLES_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       power_button_input_i,
  input  wire logic       standby_input_i,
  input  wire logic       button_mode_default_i,
  input  wire logic [1:0] button_debounce_default_i,
  input  wire logic [1:0] long_press_delay_default_i,
  input  wire logic [7:0] host_reset_release_slot_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            host_reset_out_n_o,
  output logic            host_reset_oe_o,
  output logic            irq_out_n_o,
  output logic            irq_oe_o,
  output logic            standby_mode_o,
  output logic            system_on_o
);

  // ************************************************************
  // state record
  // ************************************************************
  typedef struct packed {
    logic                  pin_s1;
    logic                  pin_s2;
    logic                  sb_s1;
    logic                  sb_s2;
    logic                  db;
    logic [9:0]            db_ms;
    logic [16:0]           db_pre;
    logic [16:0]           hold_pre;
    logic [14:0]           hold_ms;
    logic [6:0]            lat;
    logic [6:0]            mask;
    logic                  mode;
    logic                  rst_en;
    logic [1:0]            dly_sel;
    logic [1:0]            dbnc_sel;
    logic                  sb_inv;
    logic                  test_on;
    logic [13:0]           test_cnt;
    pcpl_pkg::pcpl_state_t state;
    logic [9:0]            slot_pre;
    logic [7:0]            slot;
    logic [11:0]           disch_cnt;
    logic                  reboot;
    logic                  host_rst_n;
    logic                  irq_n;
    logic                  standby;
    logic [7:0]            rdata;
  } pcpl_regs_t;

  pcpl_regs_t s;
  pcpl_regs_t next_s;

  // ************************************************************
  // helpers
  // ************************************************************
  // debounce time for the given select and edge direction
  function automatic logic [9:0] pcpl_dbnc_ms(input logic [1:0] sel, input logic falling);
    logic [9:0] t;
    t = pcpl_pkg::DBNC_32_MS;
    if (falling) begin
      case (sel)
        2'h2:    t = pcpl_pkg::DBNC_125_MS;
        2'h3:    t = pcpl_pkg::DBNC_750_MS;
        default: t = pcpl_pkg::DBNC_32_MS;
      endcase
    end
    return t;
  endfunction

  // long press delay for the given select
  function automatic logic [14:0] pcpl_long_ms(input logic [1:0] sel);
    logic [14:0] t;
    case (sel)
      2'h0:    t = pcpl_pkg::LONG_2S_MS;
      2'h1:    t = pcpl_pkg::LONG_4S_MS;
      2'h2:    t = pcpl_pkg::LONG_8S_MS;
      default: t = pcpl_pkg::LONG_16S_MS;
    endcase
    return t;
  endfunction

  // ************************************************************
  // next-state logic
  // ************************************************************
  logic       db_tick;
  logic       hold_tick;
  logic       slot_tick;
  logic       press_ev;
  logic       release_ev;
  logic       long_ev;
  logic [6:0] set_v;
  logic [6:0] clr_v;
  logic [9:0] dbnc_thr;

  always_comb begin
    next_s     = s;
    set_v      = '0;
    clr_v      = '0;
    press_ev   = 1'b0;
    release_ev = 1'b0;
    long_ev    = 1'b0;

    // two-stage input synchronisers
    next_s.pin_s1 = power_button_input_i;
    next_s.pin_s2 = s.pin_s1;
    next_s.sb_s1  = standby_input_i;
    next_s.sb_s2  = s.sb_s1;

    // debounce: count ms while the input differs, restart on bounce back
    db_tick  = (s.db_pre == 17'(MS_CYCLES - 1));
    dbnc_thr = pcpl_dbnc_ms(s.dbnc_sel, s.db);
    if (s.pin_s2 == s.db) begin
      next_s.db_ms  = '0;
      next_s.db_pre = '0;
    end else if (db_tick) begin
      next_s.db_pre = '0;
      if (s.db_ms + 10'h001 >= dbnc_thr) begin
        next_s.db    = s.pin_s2;
        next_s.db_ms = '0;
        press_ev     = s.db;
        release_ev   = !s.db;
      end else begin
        next_s.db_ms = s.db_ms + 10'h001;
      end
    end else begin
      next_s.db_pre = s.db_pre + 17'h00001;
    end

    // hold timer: prescaled ms count while pressed, cleared on release
    hold_tick = (s.hold_pre == 17'(MS_CYCLES - 1));
    if (s.db) begin
      next_s.hold_pre = '0;
      next_s.hold_ms  = '0;
    end else if (hold_tick) begin
      next_s.hold_pre = '0;
      if (s.hold_ms != pcpl_pkg::HOLD_MAX_MS) begin
        next_s.hold_ms = s.hold_ms + 15'h0001;
      end
    end else begin
      next_s.hold_pre = s.hold_pre + 17'h00001;
    end

    // hold thresholds fire once on the ms they are crossed
    if (!s.db && hold_tick) begin
      set_v[pcpl_pkg::INT_HOLD1] = (next_s.hold_ms == pcpl_pkg::HOLD1_MS);
      set_v[pcpl_pkg::INT_HOLD2] = (next_s.hold_ms == pcpl_pkg::HOLD2_MS);
      set_v[pcpl_pkg::INT_HOLD3] = (next_s.hold_ms == pcpl_pkg::HOLD3_MS);
      set_v[pcpl_pkg::INT_HOLD4] = (next_s.hold_ms == pcpl_pkg::HOLD4_MS);
      set_v[pcpl_pkg::INT_HOLD8] = (next_s.hold_ms == pcpl_pkg::HOLD8_MS);
      long_ev = (next_s.hold_ms == pcpl_long_ms(s.dly_sel));
    end

    // press and release latches only while the system is on
    if (s.state == pcpl_pkg::PCPL_ON) begin
      set_v[pcpl_pkg::INT_PRESS]   = press_ev;
      set_v[pcpl_pkg::INT_RELEASE] = release_ev;
    end

    // register writes
    if (wr_i) begin
      case (addr_i)
        pcpl_pkg::ADDR_CTRL: begin
          next_s.rst_en   = wdata_i[pcpl_pkg::CTRL_RST_EN];
          next_s.dly_sel  = wdata_i[pcpl_pkg::CTRL_DLY_LO +: 2];
          next_s.dbnc_sel = wdata_i[pcpl_pkg::CTRL_DBNC_LO +: 2];
          next_s.sb_inv   = wdata_i[pcpl_pkg::CTRL_SB_INV];
          if (wdata_i[pcpl_pkg::CTRL_TEST] && !s.test_on) begin
            next_s.test_on  = 1'b1;
            next_s.test_cnt = '0;
          end
        end
        pcpl_pkg::ADDR_LATCH: clr_v       = wdata_i[6:0];
        pcpl_pkg::ADDR_MASK:  next_s.mask = wdata_i[6:0];
        default: ;
      endcase
    end

    // latches: set wins over a clear in the same cycle
    next_s.lat = (s.lat & ~clr_v) | set_v;

    // self-test pulse timer
    if (s.test_on) begin
      if (s.test_cnt == 14'(TEST_CYCLES - 1)) begin
        next_s.test_on  = 1'b0;
        next_s.test_cnt = '0;
      end else begin
        next_s.test_cnt = s.test_cnt + 14'h0001;
      end
    end

    // sequence slot time base, runs only while sequencing
    slot_tick = (s.slot_pre == 10'(pcpl_pkg::SLOT_CYCLES - 1));
    if (s.state == pcpl_pkg::PCPL_PWRUP || s.state == pcpl_pkg::PCPL_PWRDN) begin
      next_s.slot_pre = slot_tick ? 10'h000 : s.slot_pre + 10'h001;
    end else begin
      next_s.slot_pre = '0;
    end

    // power state machine
    case (s.state)
      pcpl_pkg::PCPL_OFF: begin
        next_s.host_rst_n = 1'b0;
        if (s.mode ? press_ev : s.db) begin
          next_s.state = pcpl_pkg::PCPL_PWRUP;
          next_s.slot  = '0;
        end
      end
      pcpl_pkg::PCPL_PWRUP: begin
        if (slot_tick) begin
          if (s.slot == host_reset_release_slot_i) begin
            next_s.host_rst_n = 1'b1;
          end
          if (s.slot == 8'hff) begin
            next_s.host_rst_n = 1'b1;
            next_s.state      = pcpl_pkg::PCPL_ON;
          end else begin
            next_s.slot = s.slot + 8'h01;
          end
        end
      end
      pcpl_pkg::PCPL_ON: begin
        next_s.host_rst_n = 1'b1;
        if (!s.mode && !s.db) begin
          next_s.state  = pcpl_pkg::PCPL_PWRDN;
          next_s.slot   = '0;
          next_s.reboot = 1'b0;
        end else if (s.mode && long_ev) begin
          next_s.state  = pcpl_pkg::PCPL_PWRDN;
          next_s.slot   = '0;
          next_s.reboot = s.rst_en;
        end
      end
      pcpl_pkg::PCPL_PWRDN: begin
        if (slot_tick) begin
          if (s.slot == ~host_reset_release_slot_i) begin
            next_s.host_rst_n = 1'b0;
          end
          if (s.slot == 8'hff) begin
            next_s.host_rst_n = 1'b0;
            next_s.disch_cnt  = '0;
            next_s.state      = s.reboot ? pcpl_pkg::PCPL_DISCH : pcpl_pkg::PCPL_OFF;
          end else begin
            next_s.slot = s.slot + 8'h01;
          end
        end
      end
      pcpl_pkg::PCPL_DISCH: begin
        next_s.host_rst_n = 1'b0;
        if (s.disch_cnt == 12'(pcpl_pkg::DISCH_CYCLES - 1)) begin
          // discharge done: reload defaults and power back up
          next_s.state    = pcpl_pkg::PCPL_PWRUP;
          next_s.slot     = '0;
          next_s.reboot   = 1'b0;
          next_s.dbnc_sel = button_debounce_default_i;
          next_s.dly_sel  = long_press_delay_default_i;
          next_s.rst_en   = pcpl_pkg::RST_EN_RST;
          next_s.sb_inv   = pcpl_pkg::SB_INV_RST;
          next_s.mask     = pcpl_pkg::MASK_RST;
        end else begin
          next_s.disch_cnt = s.disch_cnt + 12'h001;
        end
      end
      default: begin
        next_s.state      = pcpl_pkg::PCPL_OFF;
        next_s.host_rst_n = 1'b0;
      end
    endcase

    // standby only honoured while on
    next_s.standby = (s.state == pcpl_pkg::PCPL_ON) && (s.sb_s2 ^ s.sb_inv);

    // interrupt pin: any unmasked latch or the test pulse pulls it low
    next_s.irq_n = !((|(next_s.lat & ~next_s.mask)) || next_s.test_on);

    // read data, valid the cycle after the strobe
    next_s.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        pcpl_pkg::ADDR_CTRL: begin
          next_s.rdata[pcpl_pkg::CTRL_RST_EN]        = s.rst_en;
          next_s.rdata[pcpl_pkg::CTRL_DLY_LO +: 2]   = s.dly_sel;
          next_s.rdata[pcpl_pkg::CTRL_DBNC_LO +: 2]  = s.dbnc_sel;
          next_s.rdata[pcpl_pkg::CTRL_SB_INV]        = s.sb_inv;
          next_s.rdata[pcpl_pkg::CTRL_TEST]          = s.test_on;
        end
        pcpl_pkg::ADDR_LATCH: next_s.rdata[6:0] = s.lat;
        pcpl_pkg::ADDR_MASK:  next_s.rdata[6:0] = s.mask;
        pcpl_pkg::ADDR_STATUS: begin
          next_s.rdata[pcpl_pkg::STAT_LEVEL]   = s.pin_s2;
          next_s.rdata[pcpl_pkg::STAT_STANDBY] = s.standby;
          next_s.rdata[pcpl_pkg::STAT_MODE]    = s.mode;
          next_s.rdata[pcpl_pkg::STAT_ON]      = (s.state == pcpl_pkg::PCPL_ON);
          next_s.rdata[pcpl_pkg::STAT_HRST]    = s.host_rst_n;
        end
        default: next_s.rdata = '0;
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s          <= '0;
      s.pin_s1   <= 1'b1;
      s.pin_s2   <= 1'b1;
      s.db       <= 1'b1;
      s.mode     <= button_mode_default_i;
      s.dbnc_sel <= button_debounce_default_i;
      s.dly_sel  <= long_press_delay_default_i;
      s.rst_en   <= pcpl_pkg::RST_EN_RST;
      s.sb_inv   <= pcpl_pkg::SB_INV_RST;
      s.mask     <= pcpl_pkg::MASK_RST;
      s.state    <= pcpl_pkg::PCPL_OFF;
      s.irq_n    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops, system_on_o decoded from the state; open-drain enables mirror low drive
  assign rdata_o            = s.rdata;
  assign host_reset_out_n_o = s.host_rst_n;
  assign host_reset_oe_o    = !s.host_rst_n;
  assign irq_out_n_o        = s.irq_n;
  assign irq_oe_o           = !s.irq_n;
  assign standby_mode_o     = s.standby;
  assign system_on_o        = (s.state == pcpl_pkg::PCPL_ON);

endmodule

`default_nettype wire

// File: pcpl_top_chk.sv
// concurrent checks on the control-pin logic ports
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// port checker
// ************************************************************
module pcpl_top_chk #(
  parameter int unsigned TEST_CYCLES = 8
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rdata_o,
  input  wire logic       host_reset_out_n_o,
  input  wire logic       host_reset_oe_o,
  input  wire logic       irq_out_n_o,
  input  wire logic       irq_oe_o,
  input  wire logic       standby_mode_o,
  input  wire logic       system_on_o
);
  // slack for a self-test pulse that may overlap the mask write
  localparam int MASK_WAIT = TEST_CYCLES + 4;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read answer");
  a_rdata_top_bit: assert property ($past(rd_i) |-> rdata_o[7] == 1'b0)
    else $error("read data bit 7 set");
  a_irq_oe_pair: assert property (irq_oe_o == !irq_out_n_o)
    else $error("interrupt enable does not match level");
  a_hrst_oe_pair: assert property (host_reset_oe_o == !host_reset_out_n_o)
    else $error("host reset enable does not match level");
  a_hrst_in_on: assert property (system_on_o |-> host_reset_out_n_o)
    else $error("host reset low while on");
  a_standby_needs_on: assert property (standby_mode_o |-> system_on_o)
    else $error("standby outside on state");
  a_selftest_low: assert property (
    wr_i && addr_i == 8'h00 && wdata_i[6] |-> ##2 !irq_out_n_o [*4])
    else $error("self-test pulse missing");
  a_mask_all_release: assert property (
    wr_i && addr_i == 8'h02 && wdata_i[6:0] == 7'h7f |-> ##[1:MASK_WAIT] irq_out_n_o)
    else $error("interrupt held low with all masked");
  a_reset_values: assert property ($fell(sys_rst_i) |->
    !host_reset_out_n_o && irq_out_n_o && !system_on_o && rdata_o == 8'h00)
    else $error("outputs wrong after reset");
endmodule
bind pcpl_top pcpl_top_chk #(.TEST_CYCLES(TEST_CYCLES)) u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .host_reset_out_n_o(host_reset_out_n_o),
  .host_reset_oe_o(host_reset_oe_o), .irq_out_n_o(irq_out_n_o), .irq_oe_o(irq_oe_o),
  .standby_mode_o(standby_mode_o), .system_on_o(system_on_o));
`default_nettype wire

// File: pcpl_button_model.sv
// push button and host-side pin wiring with pull-ups
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// button and open-drain wires
// ************************************************************
module pcpl_button_model (
  input  wire logic press_i,
  input  wire logic host_reset_oe_i,
  input  wire logic irq_oe_i,
  output logic      pin_o,
  output logic      host_reset_wire_o,
  output logic      irq_wire_o
);
  // pressed switch shorts pin to ground, pull-up otherwise
  assign pin_o = press_i ? 1'b0 : 1'b1;
  // open-drain lines rest high through the host pull-ups
  assign host_reset_wire_o = host_reset_oe_i ? 1'b0 : 1'b1;
  assign irq_wire_o = irq_oe_i ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: test_pmic_control_pin_logic.sv
// self-checking bench for the control-pin logic
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
// ************************************************************
// bench top
// ************************************************************
module test_pmic_control_pin_logic;
  localparam int unsigned MS = 4;
  localparam int unsigned TC = 8;
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       press = 1'b0;
  logic       pin;
  logic       stby = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic       hrst_n, hrst_oe, irq_n, irq_oe, sb_mode, sys_on, hrst_w, irq_w;
  int         bad_count = 0;
  int         cmp_count = 0;
  pcpl_top #(.MS_CYCLES(MS), .TEST_CYCLES(TC)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .power_button_input_i(pin),
    .standby_input_i(stby), .button_mode_default_i(1'b1),
    .button_debounce_default_i(2'b10), .long_press_delay_default_i(2'b01),
    .host_reset_release_slot_i(8'h00), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .host_reset_out_n_o(hrst_n),
    .host_reset_oe_o(hrst_oe), .irq_out_n_o(irq_n), .irq_oe_o(irq_oe),
    .standby_mode_o(sb_mode), .system_on_o(sys_on));
  pcpl_button_model u_btn (
    .press_i(press), .host_reset_oe_i(hrst_oe), .irq_oe_i(irq_oe),
    .pin_o(pin), .host_reset_wire_o(hrst_w), .irq_wire_o(irq_w));
  // clock generator
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // single-cycle write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read, answer sampled in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // verdict and end of run
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    logic [7:0] d;
    int         n;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h00, d); `CHK(d, 8'h12)
    rd(8'h02, d); `CHK(d, 8'h00)
    rd(8'h01, d); `CHK(d, 8'h00)
    rd(8'h03, d); `CHK(d, 8'h05)
    rd(8'h07, d); `CHK(d, 8'h00)
    `CHK(hrst_w, 1'b0)
    // self-test pulse and self-clear
    wr(8'h00, 8'h52);
    #1 `CHK(irq_w, 1'b0)
    rd(8'h00, d); `CHK(d, 8'h52)
    repeat (12) @(posedge clk_i);
    #1 `CHK(irq_w, 1'b1)
    rd(8'h00, d); `CHK(d, 8'h12)
    // short press then bounce back restarts the falling count
    @(posedge clk_i);
    press <= 1'b1;
    repeat (100 * MS) @(posedge clk_i);
    rd(8'h03, d); `CHK(d, 8'h04)
    @(posedge clk_i);
    press <= 1'b0;
    repeat (100) @(posedge clk_i);
    #1 `CHK(hrst_w, 1'b0)
    // full press starts power-up, host reset leaves at slot zero
    @(posedge clk_i);
    press <= 1'b1;
    repeat (120 * MS) @(posedge clk_i);
    #1 `CHK(hrst_w, 1'b0)
    n = 0;
    while (hrst_n !== 1'b1 && n < 1400) begin
      @(posedge clk_i);
      n++;
    end
    #1 `CHK(hrst_w, 1'b1)
    // one-second hold latch, mask and write-one clear; margin past 4000 cycles
    repeat (3200) @(posedge clk_i);
    rd(8'h01, d); `CHK(d, 8'h04)
    `CHK(irq_w, 1'b0)
    wr(8'h02, 8'h7f);
    repeat (2) @(posedge clk_i);
    #1 `CHK(irq_w, 1'b1)
    wr(8'h02, 8'h00);
    wr(8'h01, 8'h00);
    rd(8'h01, d); `CHK(d, 8'h04)
    `CHK(irq_w, 1'b0)
    wr(8'h01, 8'h04);
    repeat (2) @(posedge clk_i);
    rd(8'h01, d); `CHK(d, 8'h00)
    `CHK(irq_w, 1'b1)
    // keep holding past eight seconds
    repeat (28500) @(posedge clk_i);
    rd(8'h01, d); `CHK(d, 8'h78)
    @(posedge clk_i);
    press <= 1'b0;
    repeat (200 * MS) @(posedge clk_i);
    rd(8'h03, d); `CHK(d, 8'h15)
    rd(8'h01, d); `CHK(d, 8'h78)
    `CHK(sb_mode, 1'b0)
    tally_and_finish();
  end
endmodule
`default_nettype wire
